// [core/telescope_safety_interlock.sv]
// Telescope safety interlock with fault filter, watchdogs and AXI4-Lite registers
//
// What this block does
// - Bypass masks only the ten travel faults.
// - Fault passes two latch-clock rising-edge flops.
// - Final fault freezes latches, forces fault outputs.
// - Faults that clear before the latches close are ignored.
// - Reset low or fault forces outputs.
// - Fault state: relays and brake lamp one, control lamp and redundant enable zero.
// - Dome relay low when either dome control.
// - Brake output high when switch or release low.
// - Brake lamp follows amplifier/brake output high.
// - Redundant enable from reset, brake, watchdogs.
// - Two watchdogs, on heartbeat and latch clock, each gate the redundant enable.
// - Redundant enable active high, opposite polarity.
// - Heartbeat falling edges restart 600 ms watchdog.
// - Latches transparent high, hold at falling edge.
// - Nine comparator trips are latched faults.
// - Dome relay output low on, high off.
// - Each latched fault shown on status output.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.

`include "safety_consts.svh"

module telescope_safety_interlock #(
    parameter int unsigned AW          = 8,
    parameter int unsigned WD_HOST_CYC = `WD_HOST_CYC,
    parameter int unsigned WD_LCLK_CYC = `WD_LCLK_CYC
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [AW-1:0]          s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [AW-1:0]          s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   latch_clk,
    input  wire logic                   heartbeat,
    input  wire logic                   reset_in_n,
    input  wire logic                   limit_bypass,
    input  wire logic [7:0]             travel_stop,
    input  wire logic                   horizon_stop,
    input  wire logic                   spare_fault,
    input  wire logic [1:0]             overspeed_trip,
    input  wire logic [3:0]             tel_overcurrent_trip,
    input  wire logic [2:0]             dome_overcurrent_trip,
    input  wire logic                   emergency_stop,
    input  wire logic                   paddle_stop,
    input  wire logic                   dome_sw_control,
    input  wire logic                   dome_paddle_control,
    input  wire logic                   panel_tel_switch,
    input  wire logic                   brake_release,
    output logic [`NUM_FAULTS-1:0]      fault_latched,
    output logic                        dome_enable_n,
    output logic                        tel_enable_n,
    output logic                        panel_control_lamp,
    output logic                        panel_brake_lamp,
    output logic                        tel_enable_redundant,
    output logic                        irq
);
    import safety_pkg::*;

    localparam logic [`WD_CNT_W-1:0] WD_H_LIM = `WD_CNT_W'(WD_HOST_CYC);
    localparam logic [`WD_CNT_W-1:0] WD_L_LIM = `WD_CNT_W'(WD_LCLK_CYC);

    state_t s_r;
    state_t s_nxt;

    logic                    wr_go;
    logic                    rd_go;
    logic [`NUM_FAULTS-1:0]  raw_fault;
    logic [`NUM_FAULTS-1:0]  masked_fault;
    logic                    lc_rise;
    logic                    lc_edge;
    logic                    hb_fall;
    logic                    fault_state;
    logic [`IRQ_W-1:0]       irq_event;
    logic [`IRQ_W-1:0]       irq_clear;
    reg_sel_t                wsel;
    reg_sel_t                rsel;
    logic [`WD_CNT_W:0]      wd_h_step;
    logic [`WD_CNT_W:0]      wd_l_step;

    // Register index from a byte address; upper bits must be zero
    function automatic reg_sel_t decode(input logic [AW-1:0] addr);
        reg_sel_t sel;
        sel = REG_NONE;
        case (addr)
            AW'(`OFF_CTRL):     sel = REG_CTRL;
            AW'(`OFF_FAULTS):   sel = REG_FAULTS;
            AW'(`OFF_FLAGS):    sel = REG_FLAGS;
            AW'(`OFF_IRQ_STAT): sel = REG_IRQ_STAT;
            AW'(`OFF_IRQ_MASK): sel = REG_IRQ_MASK;
            default:            sel = REG_NONE;
        endcase
        return sel;
    endfunction

    // One watchdog tick: {expired, count}; a restart always wins
    function automatic logic [`WD_CNT_W:0] wd_step(
        input logic [`WD_CNT_W-1:0] cnt,
        input logic                 restart,
        input logic [`WD_CNT_W-1:0] lim
    );
        logic [`WD_CNT_W:0] res;
        res = '0;
        if (restart) begin
            res = '0;
        end else if (cnt >= lim) begin
            res = {1'b1, cnt};
        end else begin
            res = {1'b0, cnt + `WD_CNT_W'(1)};
        end
        return res;
    endfunction

    // Slave takes address and data together; one response outstanding at a time
    assign s_axi_awready = aresetn & s_axi_awvalid & s_axi_wvalid & ~s_r.bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = aresetn & ~s_r.rvalid;
    assign wr_go         = s_axi_awready;
    assign rd_go         = s_axi_arready & s_axi_arvalid;
    assign wsel          = decode(s_axi_awaddr);
    assign rsel          = decode(s_axi_araddr);

    // Fault vector: maskable travel faults sit in the low bits
    assign raw_fault = {paddle_stop, emergency_stop,
                        dome_overcurrent_trip, tel_overcurrent_trip, overspeed_trip,
                        spare_fault, horizon_stop, travel_stop};
    assign masked_fault = {raw_fault[`NUM_FAULTS-1:`NUM_MASKABLE],
                           raw_fault[`NUM_MASKABLE-1:0] & {`NUM_MASKABLE{~limit_bypass}}};

    // Edge detectors look only at the second and third sync stages
    assign lc_rise = s_r.lc_s2 & ~s_r.lc_s3;
    assign lc_edge = s_r.lc_s2 ^ s_r.lc_s3;
    assign hb_fall = ~s_r.hb_s2 & s_r.hb_s3;

    assign wd_h_step = wd_step(s_r.wd_h_cnt, hb_fall, WD_H_LIM);
    assign wd_l_step = wd_step(s_r.wd_l_cnt, lc_edge, WD_L_LIM);

    // Final stage is active high: ff_b high means the board is in fault
    assign fault_state = ~reset_in_n | s_r.ff_b;

    always_comb begin
        s_nxt = s_r;
        irq_clear = '0;

        s_nxt.hb_s1 = heartbeat;
        s_nxt.hb_s2 = s_r.hb_s1;
        s_nxt.hb_s3 = s_r.hb_s2;
        s_nxt.lc_s1 = latch_clk;
        s_nxt.lc_s2 = s_r.lc_s1;
        s_nxt.lc_s3 = s_r.lc_s2;

        // Latches follow inputs while the latch clock is high and freeze once
        // the final fault is up, so the cause stays visible until reset
        if (!reset_in_n) begin
            s_nxt.latch = '0;
        end else if (!s_r.ff_b && s_r.lc_s2) begin
            s_nxt.latch = masked_fault;
        end

        // Two rising-edge stages; a fault held when the latches close passes at the second rise
        if (!reset_in_n) begin
            s_nxt.ff_a = 1'b0;
            s_nxt.ff_b = 1'b0;
        end else if (lc_rise) begin
            s_nxt.ff_a = (|s_r.latch) | s_r.force_fault;
            s_nxt.ff_b = s_r.ff_a | s_r.ff_b;
        end

        {s_nxt.wd_h_exp, s_nxt.wd_h_cnt} = wd_h_step;
        {s_nxt.wd_l_exp, s_nxt.wd_l_cnt} = wd_l_step;

        // Outputs; fault state wins over every control input
        if (fault_state) begin
            s_nxt.dome     = 1'b1;
            s_nxt.tel      = 1'b1;
            s_nxt.ctl_lamp = 1'b0;
        end else begin
            s_nxt.dome     = ~(dome_sw_control | dome_paddle_control);
            s_nxt.tel      = ~(panel_tel_switch & brake_release);
            s_nxt.ctl_lamp = panel_tel_switch & brake_release;
        end
        s_nxt.brk_lamp = s_nxt.tel;
        // Opposite polarity to tel: a stuck line cannot enable both paths
        s_nxt.ren = reset_in_n & ~s_nxt.tel & ~(s_r.wd_h_exp | s_r.wd_l_exp);

        // Register writes
        if (wr_go) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = (wsel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            if (s_axi_wstrb[0]) begin
                case (wsel)
                    REG_CTRL:     s_nxt.force_fault = s_axi_wdata[`CTRL_FORCE];
                    REG_IRQ_STAT: irq_clear = s_axi_wdata[`IRQ_W-1:0];
                    REG_IRQ_MASK: s_nxt.irq_mask = s_axi_wdata[`IRQ_W-1:0];
                    default:      s_nxt.force_fault = s_r.force_fault;
                endcase
            end
        end else if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Register reads
        if (rd_go) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = `RESP_OKAY;
            s_nxt.rdata  = '0;
            case (rsel)
                REG_CTRL:     s_nxt.rdata[`CTRL_FORCE] = s_r.force_fault;
                REG_FAULTS:   s_nxt.rdata[`NUM_FAULTS-1:0] = s_r.latch;
                REG_FLAGS: begin
                    s_nxt.rdata[`FLG_FINAL_OK]  = ~s_r.ff_b;
                    s_nxt.rdata[`FLG_WD_HOST]   = s_r.wd_h_exp;
                    s_nxt.rdata[`FLG_WD_LCLK]   = s_r.wd_l_exp;
                    s_nxt.rdata[`FLG_DOME]      = s_r.dome;
                    s_nxt.rdata[`FLG_TEL]       = s_r.tel;
                    s_nxt.rdata[`FLG_REDUNDANT] = s_r.ren;
                end
                REG_IRQ_STAT: s_nxt.rdata[`IRQ_W-1:0] = s_r.irq_stat;
                REG_IRQ_MASK: s_nxt.rdata[`IRQ_W-1:0] = s_r.irq_mask;
                default:      s_nxt.rresp = `RESP_SLVERR;
            endcase
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // Sticky events; a new event beats a clear in the same cycle
        irq_event = '0;
        irq_event[`IRQ_FAULT]   = s_nxt.ff_b & ~s_r.ff_b;
        irq_event[`IRQ_WD_HOST] = s_nxt.wd_h_exp & ~s_r.wd_h_exp;
        irq_event[`IRQ_WD_LCLK] = s_nxt.wd_l_exp & ~s_r.wd_l_exp;
        s_nxt.irq_stat = (s_r.irq_stat & ~irq_clear) | irq_event;
        s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r          <= '0;
            s_r.dome     <= `RST_DOME;
            s_r.tel      <= `RST_TEL;
            s_r.ctl_lamp <= `RST_CTL_LAMP;
            s_r.brk_lamp <= `RST_BRK_LAMP;
            s_r.ren      <= `RST_REDUNDANT;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fault_latched        = s_r.latch;
    assign dome_enable_n        = s_r.dome;
    assign tel_enable_n         = s_r.tel;
    assign panel_control_lamp   = s_r.ctl_lamp;
    assign panel_brake_lamp     = s_r.brk_lamp;
    assign tel_enable_redundant = s_r.ren;
    assign irq                  = s_r.irq;
    assign s_axi_bvalid         = s_r.bvalid;
    assign s_axi_bresp          = s_r.bresp;
    assign s_axi_rvalid         = s_r.rvalid;
    assign s_axi_rresp          = s_r.rresp;
    assign s_axi_rdata          = s_r.rdata;

endmodule

// [core/safety_consts.svh]
// Offsets, field positions, reset values and timing counts of the safety interlock
`ifndef SAFETY_CONSTS_SVH
`define SAFETY_CONSTS_SVH

`define CLK_HZ          50000000
`define LATCH_PERIOD_MS 133
`define WD_HOST_MS      600
`define WD_LCLK_MS      300
`define WD_HOST_CYC     (`WD_HOST_MS * (`CLK_HZ / 1000))
`define WD_LCLK_CYC     (`WD_LCLK_MS * (`CLK_HZ / 1000))
`define WD_CNT_W        25

`define NUM_FAULTS      21
`define NUM_MASKABLE    10

`define OFF_CTRL        8'h00
`define OFF_FAULTS      8'h04
`define OFF_FLAGS       8'h08
`define OFF_IRQ_STAT    8'h0c
`define OFF_IRQ_MASK    8'h10

`define CTRL_FORCE      0
`define IRQ_FAULT       0
`define IRQ_WD_HOST     1
`define IRQ_WD_LCLK     2
`define IRQ_W           3

`define FLG_FINAL_OK    0
`define FLG_WD_HOST     1
`define FLG_WD_LCLK     2
`define FLG_DOME        3
`define FLG_TEL         4
`define FLG_REDUNDANT   5

`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`define RST_DOME        1'b1
`define RST_TEL         1'b1
`define RST_CTL_LAMP    1'b0
`define RST_BRK_LAMP    1'b1
`define RST_REDUNDANT   1'b0

`endif

// [core/safety_pkg.sv]
// Types shared by the safety interlock
`include "safety_consts.svh"

package safety_pkg;

    typedef struct packed {
        logic                     hb_s1;
        logic                     hb_s2;
        logic                     hb_s3;
        logic                     lc_s1;
        logic                     lc_s2;
        logic                     lc_s3;
        logic [`NUM_FAULTS-1:0]   latch;
        logic                     ff_a;
        logic                     ff_b;
        logic [`WD_CNT_W-1:0]     wd_h_cnt;
        logic                     wd_h_exp;
        logic [`WD_CNT_W-1:0]     wd_l_cnt;
        logic                     wd_l_exp;
        logic                     dome;
        logic                     tel;
        logic                     ctl_lamp;
        logic                     brk_lamp;
        logic                     ren;
        logic                     force_fault;
        logic [`IRQ_W-1:0]        irq_stat;
        logic [`IRQ_W-1:0]        irq_mask;
        logic                     irq;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     rvalid;
        logic [1:0]               rresp;
        logic [31:0]              rdata;
    } state_t;

    typedef enum logic [2:0] {
        REG_CTRL     = 3'b000,
        REG_FAULTS   = 3'b001,
        REG_FLAGS    = 3'b010,
        REG_IRQ_STAT = 3'b011,
        REG_IRQ_MASK = 3'b100,
        REG_NONE     = 3'b111
    } reg_sel_t;

endpackage

// [verification/safety_far_side.sv]
// Far-side model: host heartbeat and slow latch clock, each of which can be stopped
module safety_far_side #(
    parameter int LC_HALF = 40,
    parameter int HB_HALF = 50
) (
    input  wire logic aclk,
    input  wire logic lc_run,
    input  wire logic hb_run,
    output logic      latch_clk,
    output logic      heartbeat
);
    timeunit 1ns;
    timeprecision 1ps;
    int lc_cnt;
    int hb_cnt;
    initial begin
        {latch_clk, heartbeat, lc_cnt, hb_cnt} = '0;
    end
    // Scaled-down latch clock; when stopped it freezes at its level, like a lost oscillator
    always @(posedge aclk) begin
        if (lc_run) begin
            lc_cnt <= (lc_cnt == LC_HALF - 1) ? 0 : lc_cnt + 1;
            latch_clk <= latch_clk ^ (lc_cnt == LC_HALF - 1);
        end
    end
    // One falling edge per period, well inside the watchdog time
    always @(posedge aclk) begin
        if (hb_run) begin
            hb_cnt <= (hb_cnt == HB_HALF - 1) ? 0 : hb_cnt + 1;
            heartbeat <= heartbeat ^ (hb_cnt == HB_HALF - 1);
        end
    end
endmodule

// [verification/safety_interlock_chk.sv]
// Port-level checks of the safety interlock
module safety_interlock_chk #(
    parameter int unsigned WD_HOST_CYC = 200
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        heartbeat,
    input wire logic        latch_clk,
    input wire logic        reset_in_n,
    input wire logic        limit_bypass,
    input wire logic        dome_sw_control,
    input wire logic        dome_paddle_control,
    input wire logic        panel_tel_switch,
    input wire logic        brake_release,
    input wire logic [20:0] fault_latched,
    input wire logic        dome_enable_n,
    input wire logic        tel_enable_n,
    input wire logic        panel_control_lamp,
    input wire logic        panel_brake_lamp,
    input wire logic        tel_enable_redundant
);
    logic [15:0] hb_idle_r;
    logic [7:0]  lc_low_r;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        hb_idle_r <= (!aresetn || $fell(heartbeat)) ? 16'h0 : hb_idle_r + 16'h1;
        lc_low_r <= (!aresetn || latch_clk) ? 8'h0 : lc_low_r + {7'h0, lc_low_r != 8'hff};
    end
    property p_fault_state; !reset_in_n |=> dome_enable_n && tel_enable_n && !panel_control_lamp
        && panel_brake_lamp && !tel_enable_redundant; endproperty
    a_fault_state: assert property (p_fault_state) else $error("outputs not in fault state");
    property p_brake_lamp; panel_brake_lamp == tel_enable_n; endproperty
    a_brake_lamp: assert property (p_brake_lamp) else $error("brake lamp differs from brake output");
    property p_dome_on; !dome_enable_n |-> $past(dome_sw_control || dome_paddle_control) && $past(reset_in_n); endproperty
    a_dome_on: assert property (p_dome_on) else $error("dome relay on without a request");
    property p_dome_off; !(dome_sw_control || dome_paddle_control) |=> dome_enable_n; endproperty
    a_dome_off: assert property (p_dome_off) else $error("dome relay not switched off");
    property p_brake; !(panel_tel_switch && brake_release) |=> tel_enable_n; endproperty
    a_brake: assert property (p_brake) else $error("brakes not applied");
    property p_redundant; tel_enable_redundant |-> !tel_enable_n && $past(reset_in_n)
        && $past(panel_tel_switch && brake_release); endproperty
    a_redundant: assert property (p_redundant) else $error("redundant enable without all terms");
    // Margin covers the heartbeat synchroniser and the output register
    property p_host_wd; int'(hb_idle_r) > WD_HOST_CYC + 8 |-> !tel_enable_redundant; endproperty
    a_host_wd: assert property (p_host_wd) else $error("enable kept after heartbeat loss");
    property p_latch_hold; lc_low_r > 8'd6 && reset_in_n && $past(reset_in_n) && $past(reset_in_n, 2)
        |-> $stable(fault_latched); endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latches changed while latch clock low");
    property p_bypass; limit_bypass && $past(limit_bypass) && $past(limit_bypass, 2) && $past(limit_bypass, 3)
        |-> (fault_latched & ~$past(fault_latched) & 21'h3ff) == 21'h0; endproperty
    a_bypass: assert property (p_bypass) else $error("masked fault latched under bypass");
endmodule

bind telescope_safety_interlock safety_interlock_chk #(.WD_HOST_CYC(WD_HOST_CYC)) chk_i (
    .aclk, .aresetn, .heartbeat, .latch_clk, .reset_in_n, .limit_bypass, .dome_sw_control, .dome_paddle_control,
    .panel_tel_switch, .brake_release, .fault_latched, .dome_enable_n, .tel_enable_n, .panel_control_lamp,
    .panel_brake_lamp, .tel_enable_redundant);

// [verification/telescope_safety_interlock_bench.sv]
// Self-checking bench for the telescope safety interlock
`include "safety_consts.svh"
module telescope_safety_interlock_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lc_run, hb_run;
    logic        latch_clk, heartbeat, reset_in_n, limit_bypass, horizon_stop, spare_fault, emergency_stop;
    logic        paddle_stop, dome_sw_control, dome_paddle_control, panel_tel_switch, brake_release, en;
    logic        dome_enable_n, tel_enable_n, panel_control_lamp, panel_brake_lamp, tel_enable_redundant, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, overspeed_trip, rs;
    logic [2:0]  dome_overcurrent_trip;
    logic [3:0]  tel_overcurrent_trip;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, travel_stop;
    logic [20:0] fault_latched;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    int          errors = 0;
    int          n_tests = 0;
    int          k;

    telescope_safety_interlock #(.WD_HOST_CYC(200), .WD_LCLK_CYC(100)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .latch_clk, .heartbeat, .reset_in_n, .limit_bypass, .travel_stop,
        .horizon_stop, .spare_fault, .overspeed_trip, .tel_overcurrent_trip, .dome_overcurrent_trip,
        .emergency_stop, .paddle_stop, .dome_sw_control, .dome_paddle_control, .panel_tel_switch,
        .brake_release, .fault_latched, .dome_enable_n, .tel_enable_n, .panel_control_lamp,
        .panel_brake_lamp, .tel_enable_redundant, .irq);
    safety_far_side far (.aclk, .lc_run, .hb_run, .latch_clk, .heartbeat);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Order: dome relay, brake output, control lamp, brake lamp, redundant enable
    task automatic outs(input logic [4:0] e);
        @(negedge aclk);
        chk({27'h0, dome_enable_n, tel_enable_n, panel_control_lamp, panel_brake_lamp, tel_enable_redundant},
            {27'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do @(negedge aclk); while (!s_axi_awready);
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
        do @(negedge aclk); while (!s_axi_bvalid);
        rs = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic te(input string s);
        $display("Test done: %s", s);
    endtask
    task automatic test_done;
        $display("Checks: %0d, mismatches: %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Whole run is under 2000 cycles; a hang is cut off well after that
    initial begin
        #200000;
        errors++;
        $display("CHECK FAILED at %0t: timeout", $time);
        test_done();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, limit_bypass, travel_stop, horizon_stop, spare_fault} = '0;
        {overspeed_trip, tel_overcurrent_trip, dome_overcurrent_trip, emergency_stop, paddle_stop} = '0;
        {dome_sw_control, dome_paddle_control} = '0;
        {reset_in_n, panel_tel_switch, brake_release, lc_run, hb_run} = '1;
        repeat (7) @(posedge aclk);
        outs(5'b11010);
        @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge aclk);
            {dome_sw_control, dome_paddle_control, panel_tel_switch, brake_release} <= 4'(k);
            en = k[1] & k[0];
            repeat (2) @(posedge aclk);
            outs({~(k[3] | k[2]), ~en, en, ~en, en});
        end
        rd_reg(`OFF_FLAGS);
        chk(rd, 32'h21);
        rd_reg(8'h14);
        chk({rd[29:0], rs}, {30'h0, `RESP_SLVERR});
        te("controls");
        // Synced latch clock lags the pin by two cycles, so wait until the latches are closed
        @(negedge latch_clk);
        repeat (4) @(posedge aclk);
        emergency_stop <= 1'b1;
        repeat (20) @(posedge aclk);
        emergency_stop <= 1'b0;
        repeat (200) @(posedge aclk);
        outs(5'b00101);
        chk({11'h0, fault_latched}, 32'h0);
        @(posedge aclk);
        {limit_bypass, travel_stop, horizon_stop, spare_fault} <= 11'h7ff;
        repeat (200) @(posedge aclk);
        outs(5'b00101);
        chk({11'h0, fault_latched}, 32'h0);
        @(posedge aclk);
        {limit_bypass, travel_stop, horizon_stop, spare_fault} <= 11'h400;
        te("filter and bypass");
        wr(`OFF_IRQ_MASK, 32'h1);
        chk({30'h0, rs}, {30'h0, `RESP_OKAY});
        limit_bypass <= 1'b0;
        overspeed_trip <= 2'b01;
        while (fault_latched[10] !== 1'b1) @(posedge aclk);
        k = 0;
        while (tel_enable_n !== 1'b1) begin
            @(posedge latch_clk or posedge tel_enable_n);
            if (tel_enable_n !== 1'b1) k++;
        end
        chk(k, 2);
        outs(5'b11010);
        chk({11'h0, fault_latched}, 32'h400);
        chk({31'h0, irq}, 32'h1);
        @(posedge aclk);
        {overspeed_trip, dome_overcurrent_trip} <= 5'h01;
        repeat (200) @(posedge aclk);
        outs(5'b11010);
        chk({11'h0, fault_latched}, 32'h400);
        rd_reg(`OFF_FLAGS);
        chk(rd, 32'h18);
        wr(`OFF_IRQ_STAT, 32'h1);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0);
        @(posedge aclk);
        {reset_in_n, dome_overcurrent_trip} <= 4'h0;
        repeat (3) @(posedge aclk);
        outs(5'b11010);
        @(posedge aclk);
        reset_in_n <= 1'b1;
        repeat (4) @(posedge aclk);
        outs(5'b00101);
        chk({11'h0, fault_latched}, 32'h0);
        te("fault latch");
        @(posedge aclk);
        hb_run <= 1'b0;
        repeat (260) @(posedge aclk);
        outs(5'b00100);
        chk({31'h0, irq}, 32'h0);
        rd_reg(`OFF_IRQ_STAT);
        chk(rd, 32'h2);
        hb_run <= 1'b1;
        repeat (120) @(posedge aclk);
        outs(5'b00101);
        @(posedge aclk);
        lc_run <= 1'b0;
        repeat (160) @(posedge aclk);
        outs(5'b00100);
        te("watchdogs");
        // Latch clock is stopped here, so the forced fault cannot reach the filter
        wr(`OFF_CTRL, 32'h1);
        rd_reg(`OFF_CTRL);
        chk(rd, 32'h1);
        wr(8'h14, 32'h1);
        chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
        te("registers");
        test_done();
    end
endmodule
